// File: hdl/subset_map.vh
// Notes on behaviour
// - negate yields two's complement; 80 unchanged
// - negate carry set unless operand was zero
// - negate opcodes 40 50 30 70 60
// - N copies bit 7, Z when zero
// - idle 9D advances counter only, 2 cycles
// - or-accumulate keeps half-carry and carry
// - or-accumulate opcodes AA BA CA FA EA DA
// - right rotate through carry, bit0 to carry
// - right rotate opcodes 46 56 36 76 66
// - stack reload 9C sets pointer to 00FF
// - interrupt return pops five bytes, 9 cycles
// - subroutine return pops high then low
// - borrow subtract: A minus M minus carry
// - borrow subtract carry from A7 M7 R7
// - borrow subtract opcodes A2 B2 C2 F2 E2 D2
// - carry force 99 sets only carry
// - store keeps accumulator unchanged
// - store opcodes B7..F7, flags from value
`ifndef SUBSET_MAP_VH
`define SUBSET_MAP_VH
// register bus word offsets
`define CTRL_OFS     4'h0
`define PC_OFS       4'h4
`define CORE_OFS     4'h8
`define STAT_OFS     4'hc
`define CTRL_RUN     0
`define CTRL_ILL     1
// flag register layout and reset values
`define C_BIT        0
`define Z_BIT        1
`define N_BIT        2
`define FLAG_ONES    8'he0
`define FLAG_RST     8'he8
`define SP_TOP       8'hff
`define PAGE_ZERO    8'h00
`define PC_RST       16'h0000
// operation nibble (low) and mode nibble (high)
`define LO_NEG       4'h0
`define LO_SBC       4'h2
`define LO_ROR       4'h6
`define LO_STA       4'h7
`define LO_ROL       4'h9
`define LO_ORA       4'ha
`define HI_RMW_DIR   4'h3
`define HI_ACC       4'h4
`define HI_IDX       4'h5
`define HI_RMW_IX1   4'h6
`define HI_RMW_IX    4'h7
`define HI_IMM       4'ha
`define HI_DIR       4'hb
`define HI_EXT       4'hc
`define HI_IX2       4'hd
`define HI_IX1       4'he
`define HI_IX        4'hf
`define OPC_RTI      8'h80
`define OPC_RTS      8'h81
`define OPC_SEC      8'h99
`define OPC_RSP      8'h9c
`define OPC_NOP      8'h9d
// cycle counts
`define CYC_INH_AX   4'h3
`define CYC_RMW_DIR  4'h5
`define CYC_RMW_IX   4'h5
`define CYC_RMW_IX1  4'h6
`define CYC_IMPL     4'h2
`define CYC_RTI      4'h9
`define CYC_RTS      4'h6
`define CYC_IMM      4'h2
`define CYC_DIR      4'h3
`define CYC_EXT      4'h4
`define CYC_IX       4'h3
`define CYC_IX1      4'h4
`define CYC_IX2      4'h5
`define CYC_STA_ADD  4'h1
// stack pop sequence index
`define POP_FLAG     3'h0
`define POP_ACC      3'h1
`define POP_IDX      3'h2
`define POP_PCH      3'h3
`define POP_PCL      3'h4
`endif

// File: hdl/byte_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "subset_map.vh"
module byte_alu
(
	input  wire [3:0] op_i,
	input  wire [7:0] acc_i,
	input  wire [7:0] opnd_i,
	input  wire       carry_i,
	output reg  [7:0] res_o,
	output reg        carry_o,
	output wire       neg_o,
	output wire       zero_o
);
	// result and carry per operation nibble; carry passes by default
	always @*
	begin
		res_o = acc_i;
		carry_o = carry_i;
		case (op_i)
			`LO_NEG:
			begin
				res_o = 8'h00 - opnd_i;
				carry_o = |opnd_i;
			end
			`LO_ROR:
			begin
				res_o = {carry_i, opnd_i[7:1]};
				carry_o = opnd_i[0];
			end
			`LO_ROL:
			begin
				res_o = {opnd_i[6:0], carry_i};
				carry_o = opnd_i[7];
			end
			`LO_ORA:
				res_o = acc_i | opnd_i;
			`LO_SBC:
			begin
				res_o = acc_i - opnd_i - {7'h00, carry_i};
				carry_o = (~acc_i[7] & opnd_i[7])
					| (opnd_i[7] & res_o[7])
					| (res_o[7] & ~acc_i[7]);
			end
			`LO_STA:
				res_o = acc_i;
			default:
				res_o = acc_i;
		endcase
	end

	// flags follow the result byte
	assign neg_o = res_o[7];
	assign zero_o = (res_o == 8'h00);
endmodule // byte_alu
`default_nettype wire

// File: hdl/subset_core.v
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "subset_map.vh"
module subset_core
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	output wire [15:0] mem_addr_o,
	output wire        mem_rd_o,
	output wire        mem_wr_o,
	output wire [7:0]  mem_wdata_o,
	input  wire [7:0]  mem_rdata_i
);
	localparam [7:0] S_HALT  = 8'h01;
	localparam [7:0] S_FETCH = 8'h02;
	localparam [7:0] S_OPH   = 8'h04;
	localparam [7:0] S_OPL   = 8'h08;
	localparam [7:0] S_READ  = 8'h10;
	localparam [7:0] S_WRITE = 8'h20;
	localparam [7:0] S_POP   = 8'h40;
	localparam [7:0] S_PAD   = 8'h80;

	reg [7:0]  state_reg;
	reg [7:0]  state_next;
	reg [15:0] pc_reg;
	reg [15:0] pc_next;
	reg [7:0]  a_reg;
	reg [7:0]  a_next;
	reg [7:0]  x_reg;
	reg [7:0]  x_next;
	reg [7:0]  ccr_reg;
	reg [7:0]  ccr_next;
	reg [7:0]  sp_reg;
	reg [7:0]  sp_next;
	reg [7:0]  op_reg;
	reg [7:0]  op_next;
	reg [7:0]  hi_reg;
	reg [7:0]  hi_next;
	reg [3:0]  cnt_reg;
	reg [3:0]  cnt_next;
	reg [3:0]  total_reg;
	reg [3:0]  total_next;
	reg [2:0]  pop_reg;
	reg [2:0]  pop_next;
	reg [15:0] addr_reg;
	reg [15:0] addr_next;
	reg        rd_reg;
	reg        rd_next;
	reg        wr_reg;
	reg        wr_next;
	reg [7:0]  wdata_reg;
	reg [7:0]  wdata_next;
	reg        run_reg;
	reg        ill_reg;
	reg        ill_set;
	reg        ack_reg;
	reg [31:0] rdat_reg;
	reg        exe;
	reg        fin;

	wire [7:0] cur_op;
	wire [3:0] cur_hi;
	wire [3:0] cur_lo;
	wire       inh_ax;
	wire [7:0] alu_m;
	wire [7:0] alu_res;
	wire       alu_c;
	wire       alu_n;
	wire       alu_z;
	wire       last_cycle;
	wire       wb_req;
	wire       wb_wr;
	wire       ctrl_wr;
	wire [15:0] x_wide;

	// the opcode is on the data pins during fetch, then held
	assign cur_op = (state_reg == S_FETCH) ? mem_rdata_i : op_reg;
	assign cur_hi = cur_op[7:4];
	assign cur_lo = cur_op[3:0];
	assign inh_ax = (cur_hi == `HI_ACC) || (cur_hi == `HI_IDX);
	assign alu_m = !inh_ax ? mem_rdata_i :
		(cur_hi == `HI_ACC) ? a_reg : x_reg;
	assign x_wide = {8'h00, x_reg};
	assign last_cycle = (cnt_reg == total_reg - 4'h1);

	byte_alu u_alu
	(
		.op_i    (cur_lo),
		.acc_i   (a_reg),
		.opnd_i  (alu_m),
		.carry_i (ccr_reg[`C_BIT]),
		.res_o   (alu_res),
		.carry_o (alu_c),
		.neg_o   (alu_n),
		.zero_o  (alu_z)
	);

	function is_rmw;
		input [3:0] lo;
		begin
			is_rmw = (lo == `LO_NEG) || (lo == `LO_ROR)
				|| (lo == `LO_ROL);
		end
	endfunction

	// documented length of each opcode; zero marks an unknown one
	function [3:0] cycles_of;
		input [7:0] o;
		reg   [3:0] base;
		begin
			base = 4'h0;
			cycles_of = 4'h0;
			case (o[7:4])
				`HI_IMM: base = `CYC_IMM;
				`HI_DIR: base = `CYC_DIR;
				`HI_EXT: base = `CYC_EXT;
				`HI_IX2: base = `CYC_IX2;
				`HI_IX1: base = `CYC_IX1;
				`HI_IX:  base = `CYC_IX;
				default: base = 4'h0;
			endcase
			if (o == `OPC_RTI)
				cycles_of = `CYC_RTI;
			else if (o == `OPC_RTS)
				cycles_of = `CYC_RTS;
			else if (o == `OPC_SEC || o == `OPC_RSP
				|| o == `OPC_NOP)
				cycles_of = `CYC_IMPL;
			else if (is_rmw(o[3:0]))
			begin
				case (o[7:4])
					`HI_RMW_DIR: cycles_of = `CYC_RMW_DIR;
					`HI_ACC:     cycles_of = `CYC_INH_AX;
					`HI_IDX:     cycles_of = `CYC_INH_AX;
					`HI_RMW_IX1: cycles_of = `CYC_RMW_IX1;
					`HI_RMW_IX:  cycles_of = `CYC_RMW_IX;
					default:     cycles_of = 4'h0;
				endcase
			end
			else if (o[3:0] == `LO_ORA || o[3:0] == `LO_SBC)
				cycles_of = base;
			else if (o[3:0] == `LO_STA && o[7:4] != `HI_IMM
				&& base != 4'h0)
				cycles_of = base + `CYC_STA_ADD;
		end
	endfunction

	// register bus: ack one cycle after the request, write on ack
	assign wb_req = wb_cyc_i & wb_stb_i;
	assign wb_wr = wb_req & wb_we_i & ack_reg;
	assign ctrl_wr = wb_wr && (wb_adr_i == `CTRL_OFS) && wb_sel_i[0];

	// instruction sequencer, one memory access per cycle at most
	always @*
	begin
		state_next = state_reg;
		pc_next = pc_reg;
		a_next = a_reg;
		x_next = x_reg;
		ccr_next = ccr_reg;
		sp_next = sp_reg;
		op_next = op_reg;
		hi_next = hi_reg;
		cnt_next = cnt_reg + 4'h1;
		total_next = total_reg;
		pop_next = pop_reg;
		addr_next = addr_reg;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = wdata_reg;
		ill_set = 1'b0;
		exe = 1'b0;
		fin = 1'b0;
		case (state_reg)
			S_HALT:
			begin
				// counter is writable only while stopped
				if (wb_wr && wb_adr_i == `PC_OFS)
				begin
					if (wb_sel_i[1])
						pc_next[15:8] = wb_dat_i[15:8];
					if (wb_sel_i[0])
						pc_next[7:0] = wb_dat_i[7:0];
				end
				addr_next = pc_next;
				if (run_reg && !ill_reg)
				begin
					state_next = S_FETCH;
					rd_next = 1'b1;
				end
			end
			S_FETCH:
			begin
				op_next = mem_rdata_i;
				pc_next = pc_reg + 16'h0001;
				cnt_next = 4'h1;
				total_next = cycles_of(mem_rdata_i);
				if (cycles_of(mem_rdata_i) == 4'h0)
				begin
					// unknown opcode stops the core
					ill_set = 1'b1;
					state_next = S_HALT;
				end
				else if (mem_rdata_i == `OPC_SEC)
				begin
					ccr_next[`C_BIT] = 1'b1;
					fin = 1'b1;
				end
				else if (mem_rdata_i == `OPC_RSP)
				begin
					sp_next = `SP_TOP;
					fin = 1'b1;
				end
				else if (mem_rdata_i == `OPC_NOP)
					fin = 1'b1;
				else if (mem_rdata_i == `OPC_RTI
					|| mem_rdata_i == `OPC_RTS)
				begin
					// pre-increment before the first pop
					sp_next = sp_reg + 8'h01;
					addr_next = {`PAGE_ZERO, sp_next};
					rd_next = 1'b1;
					pop_next = (mem_rdata_i == `OPC_RTI)
						? `POP_FLAG : `POP_PCH;
					state_next = S_POP;
				end
				else if (inh_ax)
				begin
					exe = 1'b1;
					fin = 1'b1;
				end
				else if (cur_hi == `HI_RMW_IX || cur_hi == `HI_IX)
				begin
					addr_next = x_wide;
					if (cur_lo == `LO_STA)
					begin
						exe = 1'b1;
						wr_next = 1'b1;
						wdata_next = a_reg;
						state_next = S_WRITE;
					end
					else
					begin
						rd_next = 1'b1;
						state_next = S_READ;
					end
				end
				else
				begin
					addr_next = pc_next;
					rd_next = 1'b1;
					state_next = S_OPH;
				end
			end
			S_OPH:
			begin
				pc_next = pc_reg + 16'h0001;
				if (cur_hi == `HI_IMM)
				begin
					exe = 1'b1;
					fin = 1'b1;
				end
				else if (cur_hi == `HI_EXT || cur_hi == `HI_IX2)
				begin
					hi_next = mem_rdata_i;
					addr_next = pc_next;
					rd_next = 1'b1;
					state_next = S_OPL;
				end
				else
				begin
					if (cur_hi == `HI_RMW_DIR || cur_hi == `HI_DIR)
						addr_next = {`PAGE_ZERO, mem_rdata_i};
					else
						addr_next = x_wide + {8'h00, mem_rdata_i};
					if (cur_lo == `LO_STA)
					begin
						exe = 1'b1;
						wr_next = 1'b1;
						wdata_next = a_reg;
						state_next = S_WRITE;
					end
					else
					begin
						rd_next = 1'b1;
						state_next = S_READ;
					end
				end
			end
			S_OPL:
			begin
				pc_next = pc_reg + 16'h0001;
				if (cur_hi == `HI_EXT)
					addr_next = {hi_reg, mem_rdata_i};
				else
					addr_next = {hi_reg, mem_rdata_i} + x_wide;
				if (cur_lo == `LO_STA)
				begin
					exe = 1'b1;
					wr_next = 1'b1;
					wdata_next = a_reg;
					state_next = S_WRITE;
				end
				else
				begin
					rd_next = 1'b1;
					state_next = S_READ;
				end
			end
			S_READ:
			begin
				exe = 1'b1;
				if (is_rmw(cur_lo))
				begin
					// memory form writes back to the same address
					wr_next = 1'b1;
					wdata_next = alu_res;
					state_next = S_WRITE;
				end
				else
					fin = 1'b1;
			end
			S_WRITE:
				fin = 1'b1;
			S_POP:
			begin
				case (pop_reg)
					`POP_FLAG:
						ccr_next = mem_rdata_i | `FLAG_ONES;
					`POP_ACC:
						a_next = mem_rdata_i;
					`POP_IDX:
						x_next = mem_rdata_i;
					`POP_PCH:
						hi_next = mem_rdata_i;
					default:
						pc_next = {hi_reg, mem_rdata_i};
				endcase
				if (pop_reg == `POP_PCL)
					fin = 1'b1;
				else
				begin
					sp_next = sp_reg + 8'h01;
					addr_next = {`PAGE_ZERO, sp_next};
					rd_next = 1'b1;
					pop_next = pop_reg + 3'h1;
				end
			end
			S_PAD:
				fin = 1'b1;
			default:
				state_next = S_HALT;
		endcase

		// common result path of the byte operations
		if (exe)
		begin
			ccr_next[`N_BIT] = alu_n;
			ccr_next[`Z_BIT] = alu_z;
			ccr_next[`C_BIT] = alu_c;
			if (cur_lo == `LO_ORA || cur_lo == `LO_SBC)
				a_next = alu_res;
			else if (is_rmw(cur_lo) && cur_hi == `HI_ACC)
				a_next = alu_res;
			else if (is_rmw(cur_lo) && cur_hi == `HI_IDX)
				x_next = alu_res;
		end

		// hold until the documented cycle count has elapsed
		if (fin)
		begin
			if (state_reg != S_FETCH && last_cycle)
			begin
				addr_next = pc_next;
				if (run_reg && !ill_reg)
				begin
					state_next = S_FETCH;
					rd_next = 1'b1;
				end
				else
					state_next = S_HALT;
			end
			else
				state_next = S_PAD;
		end
	end

	// core state, flushed to a stopped core on reset
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= S_HALT;
			pc_reg <= `PC_RST;
			a_reg <= 8'h00;
			x_reg <= 8'h00;
			ccr_reg <= `FLAG_RST;
			sp_reg <= `SP_TOP;
			op_reg <= 8'h00;
			hi_reg <= 8'h00;
			cnt_reg <= 4'h0;
			total_reg <= 4'h0;
			pop_reg <= 3'h0;
			addr_reg <= `PC_RST;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			wdata_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			a_reg <= a_next;
			x_reg <= x_next;
			ccr_reg <= ccr_next;
			sp_reg <= sp_next;
			op_reg <= op_next;
			hi_reg <= hi_next;
			cnt_reg <= cnt_next;
			total_reg <= total_next;
			pop_reg <= pop_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			wr_reg <= wr_next;
			wdata_reg <= wdata_next;
		end
	end

	// bus slave; the illegal flag is set-wins over a clear
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
			run_reg <= 1'b0;
			ill_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= wb_req & ~ack_reg;
			if (ctrl_wr)
				run_reg <= wb_dat_i[`CTRL_RUN];
			ill_reg <= ill_set
				| (ill_reg & ~(ctrl_wr & wb_dat_i[`CTRL_ILL]));
			if (wb_req && !ack_reg)
			begin
				case (wb_adr_i)
					`CTRL_OFS:
						rdat_reg <= {30'h0000_0000, ill_reg, run_reg};
					`PC_OFS:
						rdat_reg <= {16'h0000, pc_reg};
					`CORE_OFS:
						rdat_reg <= {sp_reg, ccr_reg, x_reg, a_reg};
					`STAT_OFS:
						rdat_reg <= {16'h0000, op_reg, state_reg};
					default:
						rdat_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_dat_o = rdat_reg;
	assign wb_ack_o = ack_reg;
	assign mem_addr_o = addr_reg;
	assign mem_rd_o = rd_reg;
	assign mem_wr_o = wr_reg;
	assign mem_wdata_o = wdata_reg;
endmodule // subset_core
`default_nettype wire

// File: bench/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
	input  wire logic        clk_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_reg = 8'h00;

	// zero-wait read; an idle bus shows the inverse of the last byte
	assign rdata_o = rd_i ? mem[addr_i] : ~last_reg;

	// write at the edge ending the strobe cycle
	always @(posedge clk_i)
	begin
		if (wr_i)
			mem[addr_i] <= wdata_i;
		if (rd_i)
			last_reg <= mem[addr_i];
	end
endmodule // mem_model
`default_nettype wire

// File: bench/core_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module core_checker
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [15:0] mem_addr_o,
	input wire logic        mem_rd_o,
	input wire logic        mem_wr_o,
	input wire logic [7:0]  mem_rdata_i
);
	// cycles and length by high nibble; stores add one cycle
	localparam logic [63:0] CYC_LUT = 64'h3454_3200_5633_5000;
	localparam logic [63:0] LEN_LUT = 64'h1233_2211_1211_2000;
	logic [3:0]  cnt_reg;
	logic [15:0] nxt_reg;
	logic        jmp_reg;
	wire         fetch = mem_rd_o && cnt_reg == 4'h0;
	wire  [3:0]  hi = mem_rdata_i[7:4];
	wire  [3:0]  lo = mem_rdata_i[3:0];

	function automatic logic [3:0] cycles(input logic [7:0] o);
		logic rmw;
		logic alu;
		begin
			rmw = o[7:4] < 4'h8 && (o[3:0] == 4'h0 || o[3:0] == 4'h6
				|| o[3:0] == 4'h9);
			alu = o[7:4] > 4'h9 && (o[3:0] == 4'h2 || o[3:0] == 4'ha
				|| (o[3:0] == 4'h7 && o[7:4] != 4'ha));
			if (rmw || alu)
				cycles = CYC_LUT[o[7:4]*4 +: 4] + {3'h0, o[3:0] == 4'h7};
			else if (o == 8'h80)
				cycles = 4'h9;
			else if (o == 8'h81)
				cycles = 4'h6;
			else if (o == 8'h99 || o == 8'h9c || o == 8'h9d)
				cycles = 4'h2;
			else
				cycles = 4'h0;
		end
	endfunction

	// unknown opcodes load zero: the core halts, so no fetch is due
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_reg <= 4'h0;
			nxt_reg <= 16'h0000;
			jmp_reg <= 1'b0;
		end
		else if (fetch)
		begin
			cnt_reg <= (cycles(mem_rdata_i) == 4'h0) ? 4'h0
				: cycles(mem_rdata_i) - 4'h1;
			nxt_reg <= mem_addr_o + {12'h000, LEN_LUT[hi*4 +: 4]};
			jmp_reg <= mem_rdata_i[7:1] == 7'h40;
		end
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_cycle_count;
		cnt_reg == 4'h1 |=> mem_rd_o;
	endproperty
	a_cycle_count: assert property (p_cycle_count)
		else $error("next fetch not at the instruction cycle count");
	property p_next_pc;
		cnt_reg == 4'h1 && !jmp_reg |=> mem_addr_o == nxt_reg;
	endproperty
	a_next_pc: assert property (p_next_pc)
		else $error("next fetch address wrong");
	property p_store_dir;
		fetch && mem_rdata_i == 8'hb7 |-> ##2 mem_wr_o
			&& mem_addr_o == {8'h00, $past(mem_rdata_i)};
	endproperty
	a_store_dir: assert property (p_store_dir)
		else $error("direct store missed its address");
	property p_read_dir;
		fetch && (mem_rdata_i == 8'hba || mem_rdata_i == 8'hb2) |-> ##2
			mem_rd_o && mem_addr_o == {8'h00, $past(mem_rdata_i)};
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("direct operand read wrong");
	property p_no_write;
		fetch && (hi == 4'h4 || hi == 4'h5 || hi == 4'h9
			|| (hi > 4'h9 && lo != 4'h7)) |=> !mem_wr_o [*2];
	endproperty
	a_no_write: assert property (p_no_write)
		else $error("memory written by a non-storing instruction");
	property p_rti_pops;
		fetch && mem_rdata_i == 8'h80 |=> (!mem_wr_o
			&& (!mem_rd_o || mem_addr_o[15:8] == 8'h00)) [*8];
	endproperty
	a_rti_pops: assert property (p_rti_pops)
		else $error("interrupt return left the stack page");
	property p_rts_pops;
		fetch && mem_rdata_i == 8'h81 |=> (!mem_wr_o
			&& (!mem_rd_o || mem_addr_o[15:8] == 8'h00)) [*5];
	endproperty
	a_rts_pops: assert property (p_rts_pops)
		else $error("subroutine return left the stack page");
	property p_rmw_dir;
		fetch && hi == 4'h3 |-> ##[2:4] mem_wr_o
			&& mem_addr_o[15:8] == 8'h00;
	endproperty
	a_rmw_dir: assert property (p_rmw_dir)
		else $error("direct read-modify-write never wrote back");
	c_rti: cover property (fetch && mem_rdata_i == 8'h80);
	c_rts: cover property (fetch && mem_rdata_i == 8'h81);
	c_store: cover property (fetch && mem_rdata_i == 8'hb7);
endmodule // core_checker

bind subset_core core_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
	.mem_rdata_i(mem_rdata_i));
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rd_q;
	wire  [31:0] wb_dat;
	wire         wb_ack;
	wire  [15:0] m_addr;
	wire         m_rd;
	wire         m_wr;
	wire  [7:0]  m_wdata;
	wire  [7:0]  m_rdata;
	int          num_errors = 0;
	int          tests_run = 0;
	// flags a x | op o1 o2 | mem A | X flags | mem sp after
	logic [95:0] rows [33] = '{
		96'he001_1040_9d9d_00ff_10e5_0004, 96'he100_0050_9d9d_0000_00e2_0004,
		96'he033_1030_109d_8033_10e5_8004, 96'he000_1070_9d9d_0100_10e5_ff04,
		96'he000_1060_009d_7f00_10e5_8104, 96'hf130_10aa_0f9d_003f_10f1_0004,
		96'he001_10ba_109d_8081_10e4_8004, 96'he100_10ca_0010_0000_10e3_0004,
		96'he000_10fa_9d9d_4040_10e0_4004, 96'he005_10ea_009d_0a0f_10e0_0a04,
		96'hf080_10da_0000_0181_10f4_0104, 96'he180_1049_9d9d_0001_10e1_0004,
		96'he000_7f59_9d9d_0000_fee4_0004, 96'he102_1046_9d9d_0081_10e4_0004,
		96'he000_0156_9d9d_0000_00e3_0004, 96'he000_1036_109d_0100_10e3_0004,
		96'he100_1076_9d9d_0000_10e4_8004, 96'he000_1066_009d_ff00_10e1_7f04,
		96'hf105_10a2_019d_0003_10f0_0004, 96'he000_10b2_109d_01ff_10e5_0104,
		96'he180_10c2_0010_7f00_10e2_7f04, 96'he07f_10f2_9d9d_ff80_10e5_ff04,
		96'he100_10e2_009d_00ff_10e5_0004, 96'he090_10d2_0000_1080_10e4_1004,
		96'he100_10b7_109d_5500_10e3_0004, 96'he080_10c7_0010_0080_10e4_8004,
		96'he27f_10f7_9d9d_007f_10e0_7f04, 96'he001_10e7_009d_0001_10e0_0104,
		96'he501_10d7_0000_0001_10e1_0104, 96'hf512_349d_9d9d_0012_34f5_0004,
		96'hf612_3499_9d9d_0012_34f7_0004, 96'he012_349c_9d9d_0012_34e0_00ff,
		96'he812_3481_9d9d_0012_34e8_0006};

	subset_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
		.mem_addr_o(m_addr), .mem_rd_o(m_rd), .mem_wr_o(m_wr),
		.mem_wdata_o(m_wdata), .mem_rdata_i(m_rdata));
	mem_model u_mem (.clk_i(clk_i), .addr_i(m_addr), .rd_i(m_rd),
		.wr_i(m_wr), .wdata_i(m_wdata), .rdata_o(m_rdata));

	always #5 clk_i = ~clk_i;

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		begin
			tests_run++;
			if (seen !== exp)
			begin
				num_errors++;
				$display("Error %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask

	// one classic cycle; the request holds until ack is sampled high
	// no local limit: a missing ack is left to the watchdog
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			do
			begin
				@(posedge clk_i);
			end while (wb_ack !== 1'b1);
			rd_q = wb_dat;
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask

	task check_reset;
		begin
			wb(1'b0, 4'h8, 32'h0000_0000);
			chk(rd_q, 32'hffe8_0000, "core after reset");
			wb(1'b0, 4'hc, 32'h0000_0000);
			chk({24'h00_0000, rd_q[7:0]}, 32'h0000_0001, "halt state");
		end
	endtask

	// stack frame pops into the row's state, then jumps to 0300
	task run_row(input logic [95:0] r);
		int i;
		begin
			for (i = 0; i < 1024; i++)
				u_mem.mem[i] = 8'h00;
			for (i = 0; i < 3; i++)
			begin
				u_mem.mem[i] = r[95-8*i -: 8];
				u_mem.mem[768+i] = r[71-8*i -: 8];
			end
			u_mem.mem[3] = 8'h03;
			u_mem.mem[5] = 8'h03;
			u_mem.mem[6] = 8'h03;
			u_mem.mem[16] = r[47:40];
			u_mem.mem[512] = 8'h9c;
			u_mem.mem[513] = 8'h80;
			u_mem.mem[771] = 8'ha7;
			wb(1'b1, 4'h0, 32'h0000_0002);
			wb(1'b1, 4'h4, 32'h0000_0200);
			wb(1'b1, 4'h0, 32'h0000_0001);
			i = 0;
			do
			begin
				wb(1'b0, 4'hc, 32'h0000_0000);
				i++;
			end while (rd_q[7:0] !== 8'h01 && i < 50);
			chk({24'h00_0000, rd_q[7:0]}, 32'h0000_0001, "halted");
			chk({24'h00_0000, rd_q[15:8]}, 32'h0000_00a7, "last opcode");
			wb(1'b0, 4'h8, 32'h0000_0000);
			chk(rd_q, {r[7:0], r[23:16], r[31:24], r[39:32]}, "core");
			chk({24'h00_0000, u_mem.mem[16]}, {24'h00_0000, r[15:8]}, "memory");
			// every row ends on the stop byte at 0303
			wb(1'b0, 4'h4, 32'h0000_0000);
			chk(rd_q, 32'h0000_0304, "counter");
			wb(1'b0, 4'h0, 32'h0000_0000);
			chk(rd_q, 32'h0000_0003, "control");
		end
	endtask

	task end_of_test;
		begin
			$display("errors %0d checks %0d", num_errors, tests_run);
			if (num_errors == 0 && tests_run > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	// watchdog at 30000 cycles, well past the expected run of under two thousand cycles
	initial
	begin
		#300000;
		num_errors++;
		end_of_test();
	end

	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		check_reset();
		wb(1'b0, 4'h2, 32'h0000_0000);
		chk(rd_q, 32'h0000_0000, "unmapped read");
		foreach (rows[k])
			run_row(rows[k]);
		// reset in mid-program must bring back the idle state
		wb(1'b1, 4'h0, 32'h0000_0002);
		wb(1'b1, 4'h4, 32'h0000_0200);
		wb(1'b1, 4'h0, 32'h0000_0001);
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		check_reset();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
